/* logic/ardsp_top.sv */
// adc record path: notch filter, digital attenuation, pga gain control, axi4-lite registers
//
// The AXI4-Lite register port was decided locally.
`default_nettype none
module ardsp_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ardsp_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ardsp_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic signed [23:0] inSample,
	input wire logic inValid,
	output logic inReady,
	output logic signed [23:0] outSample,
	output logic outValid,
	input wire logic outReady,
	output logic [5:0] pgaGain
);
	ardsp_pkg::ardsp_state_t r;
	ardsp_pkg::ardsp_state_t n;
	logic push;
	logic pop;
	logic [1:0] cntMid;
	logic [32:0] rdRes;
	logic [32:0] wrCur;
	logic [31:0] wrMask;
	logic [31:0] wrNew;
	logic wrUpd;
	logic signed [13:0] c0;
	logic signed [13:0] c1;
	logic signed [39:0] apAcc;
	logic signed [23:0] apSat;
	logic signed [24:0] sumXa;
	logic signed [23:0] filt;
	logic [7:0] attnSteps;
	logic [4:0] volShift;
	logic [3:0] volFine;
	logic signed [40:0] volProd;
	logic signed [40:0] volScaled;
	logic signed [23:0] volOut;
	logic [22:0] peak;
	logic [3:0] lvlSteps;
	logic [3:0] fineIdx;
	logic [39:0] thrProd;
	logic [23:0] thr;
	logic above;
	logic [2:0] rateIdx;
	logic [3:0] riseSh;
	logic [3:0] fallSh;
	logic [23:0] holdPer;
	logic [23:0] risePer;
	logic [23:0] fallPer;
	logic [5:0] ceilCode;
	logic [5:0] floorCode;
	logic [5:0] topCode;

	// returns {mapped, data}; update bits are never stored and read as zero
	function automatic logic [32:0] readReg(ardsp_pkg::ardsp_state_t s, logic [9:0] idx);
		logic [31:0] d;
		logic ok;
		d = 32'h00000000;
		ok = 1'b1;
		case (idx)
			ardsp_pkg::IDX_ATTEN: d[7:0] = s.attenStage;
			ardsp_pkg::IDX_A0_LOW: d[7:0] = {s.notchOn, s.coefZeroStage[6:0]};
			ardsp_pkg::IDX_A0_HIGH: d[6:0] = s.coefZeroStage[13:7];
			ardsp_pkg::IDX_A1_LOW: d[6:0] = s.coefOneStage[6:0];
			ardsp_pkg::IDX_A1_HIGH: d[6:0] = s.coefOneStage[13:7];
			ardsp_pkg::IDX_GCTL1: d[8:0] = {s.gcOn, 2'h0, s.gainCeiling, s.gainFloor};
			ardsp_pkg::IDX_GCTL2: d[7:0] = {s.riseDelay, s.gcTarget};
			ardsp_pkg::IDX_GCTL3: d[8:0] = {s.gcKind, s.riseRate, s.fallRate};
			ardsp_pkg::IDX_CFG: d[9:0] = {s.staticGain, 1'b0, s.rateSel};
			ardsp_pkg::IDX_STATUS: d[20:0] = {s.gcState, s.notchOn, s.attenLive, 2'h0, s.pgaGain};
			ardsp_pkg::IDX_COEF: d[27:0] = {s.coefOneLive, s.coefZeroLive};
			default: ok = 1'b0;
		endcase
		return {ok, d};
	endfunction : readReg

	function automatic logic signed [23:0] sat24(logic signed [39:0] v);
		if (v > 40'(ardsp_pkg::SAMPLE_MAX)) begin
			return ardsp_pkg::SAMPLE_MAX;
		end else if (v < 40'(ardsp_pkg::SAMPLE_MIN)) begin
			return ardsp_pkg::SAMPLE_MIN;
		end
		return v[23:0];
	endfunction : sat24

	assign awready = r.awready;
	assign wready = r.wready;
	assign bresp = r.bresp;
	assign bvalid = r.bvalid;
	assign arready = r.arready;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign rvalid = r.rvalid;
	assign inReady = r.inReady;
	assign outSample = r.buf0;
	assign outValid = r.outValid;
	assign pgaGain = r.pgaGain;

	always_comb begin
		n = r;
		// all-pass section, notch output is the mean of input and all-pass
		c0 = r.coefZeroLive;
		c1 = r.coefOneLive;
		apAcc = -((40'(c0) * 40'(inSample)) >>> ardsp_pkg::NOTCH_COEF_ZERO_SHIFT)
			- ((40'(c1) * 40'(r.x1)) >>> ardsp_pkg::NOTCH_COEF_ONE_SHIFT) + 40'(r.x2)
			+ ((40'(c1) * 40'(r.ap1)) >>> ardsp_pkg::NOTCH_COEF_ONE_SHIFT)
			+ ((40'(c0) * 40'(r.ap2)) >>> ardsp_pkg::NOTCH_COEF_ZERO_SHIFT);
		apSat = sat24(apAcc);
		sumXa = 25'(inSample) + 25'(apSat);
		filt = r.notchOn ? sumXa[24:1] : inSample;
		// attenuation: 12 half-dB codes make one 6 dB shift
		attnSteps = ardsp_pkg::VOL_TOP - r.attenLive;
		volShift = 5'(attnSteps / ardsp_pkg::VOL_STEPS_PER_6DB);
		volFine = 4'(attnSteps % ardsp_pkg::VOL_STEPS_PER_6DB);
		volProd = 41'(filt) * $signed({1'b0, ardsp_pkg::VOL_FINE[volFine]});
		volScaled = volProd >>> (ardsp_pkg::FINE_SHIFT + 32'(volShift));
		volOut = (r.attenLive == 8'h00) ? 24'sh000000 : volScaled[23:0];
		// peak detector watches the filtered sample, before attenuation
		if (filt[23]) begin
			peak = (filt == ardsp_pkg::SAMPLE_MIN) ? 23'h7fffff : 23'(-filt);
		end else begin
			peak = filt[22:0];
		end
		lvlSteps = ardsp_pkg::LVL_TOP - r.gcTarget;
		fineIdx = 4'(ardsp_pkg::LVL_FINE_STRIDE * {2'h0, lvlSteps[1:0]});
		thrProd = 40'(ardsp_pkg::LEVEL_6DB) * 40'(ardsp_pkg::VOL_FINE[fineIdx]);
		thr = 24'(thrProd >> (ardsp_pkg::FINE_SHIFT + 32'(lvlSteps[3:2])));
		above = {1'b0, peak} > thr;
		// periods counted in samples, so they track the rate setting
		rateIdx = (r.rateSel > ardsp_pkg::RATE_SEL_MAX) ? ardsp_pkg::RATE_SEL_MAX : r.rateSel;
		riseSh = (r.riseRate > ardsp_pkg::RATE_SHIFT_MAX) ? ardsp_pkg::RATE_SHIFT_MAX : r.riseRate;
		fallSh = (r.fallRate > ardsp_pkg::RATE_SHIFT_MAX) ? ardsp_pkg::RATE_SHIFT_MAX : r.fallRate;
		holdPer = ardsp_pkg::HOLD_BASE[rateIdx] << (r.riseDelay - 4'h1);
		risePer = ardsp_pkg::RISE_BASE[rateIdx] << riseSh;
		fallPer = ardsp_pkg::FALL_BASE[rateIdx] << fallSh;
		if (r.gcKind) begin
			risePer = risePer >> ardsp_pkg::LIMIT_SPEEDUP;
			fallPer = fallPer >> ardsp_pkg::LIMIT_SPEEDUP;
		end
		if (risePer == 24'h000000) begin
			risePer = 24'h000001;
		end
		if (fallPer == 24'h000000) begin
			fallPer = 24'h000001;
		end
		ceilCode = {r.gainCeiling, 3'h7};
		floorCode = {r.gainFloor, 3'h0};
		topCode = (r.gcKind && r.staticGain < ceilCode) ? r.staticGain : ceilCode;

		// two-entry output buffer; a stalled receiver holds off the source
		pop = r.outValid & outReady;
		push = inValid & r.inReady;
		cntMid = r.cnt - {1'b0, pop};
		if (pop) begin
			n.buf0 = r.buf1;
		end
		if (push) begin
			if (cntMid == 2'h0) begin
				n.buf0 = volOut;
			end else begin
				n.buf1 = volOut;
			end
			n.x1 = inSample;
			n.x2 = r.x1;
			n.ap1 = apSat;
			n.ap2 = r.ap1;
			// staged values go live on a sample boundary
			if (r.attenPend) begin
				n.attenLive = r.attenStage;
				n.attenPend = 1'b0;
			end
			if (r.notchPend) begin
				n.coefZeroLive = r.coefZeroStage;
				n.coefOneLive = r.coefOneStage;
				n.notchPend = 1'b0;
			end
			// gain control, one decision per sample
			if (!r.gcOn) begin
				n.gcState = ardsp_pkg::GC_IDLE;
				n.gcCount = 24'h000000;
				n.pgaGain = r.staticGain;
			end else if (above) begin
				// ramp-down starts at once, no hold
				n.gcCount = r.gcCount + 24'h000001;
				if (r.gcState != ardsp_pkg::GC_FALL) begin
					n.gcState = ardsp_pkg::GC_FALL;
					n.gcCount = 24'h000000;
				end else if (r.gcCount >= fallPer - 24'h000001) begin
					n.gcCount = 24'h000000;
					if (r.pgaGain > floorCode) begin
						n.pgaGain = r.pgaGain - 6'h01;
					end
				end
			end else begin
				n.gcCount = r.gcCount + 24'h000001;
				unique case (r.gcState)
					ardsp_pkg::GC_IDLE, ardsp_pkg::GC_FALL: begin
						n.gcCount = 24'h000000;
						n.gcState = (r.gcKind || r.riseDelay == 4'h0) ?
							ardsp_pkg::GC_RISE : ardsp_pkg::GC_HOLD;
					end
					ardsp_pkg::GC_HOLD: begin
						if (r.gcCount >= holdPer - 24'h000001) begin
							n.gcCount = 24'h000000;
							n.gcState = ardsp_pkg::GC_RISE;
						end
					end
					ardsp_pkg::GC_RISE: begin
						if (r.gcCount >= risePer - 24'h000001) begin
							n.gcCount = 24'h000000;
							if (r.pgaGain < topCode) begin
								n.pgaGain = r.pgaGain + 6'h01;
							end
						end
					end
					default: begin
						n.gcState = ardsp_pkg::GC_IDLE;
						n.gcCount = 24'h000000;
					end
				endcase
			end
			if (r.gcOn) begin
				if (n.pgaGain > topCode) begin
					n.pgaGain = topCode;
				end
				if (n.pgaGain < floorCode) begin
					n.pgaGain = floorCode;
				end
			end
		end
		n.cnt = cntMid + {1'b0, push};
		n.outValid = n.cnt != 2'h0;
		n.inReady = n.cnt != 2'h2;

		// register bus, write side: address and data taken in either order
		if (awvalid && r.awready) begin
			n.awIdx = awaddr[ardsp_pkg::ADDR_W-1:2];
			n.awready = 1'b0;
		end
		if (wvalid && r.wready) begin
			n.wData = wdata;
			n.wStrb = wstrb;
			n.wready = 1'b0;
		end
		if (bready && r.bvalid) begin
			n.bvalid = 1'b0;
		end
		wrCur = readReg(r, r.awIdx);
		wrMask = {{8{r.wStrb[3]}}, {8{r.wStrb[2]}}, {8{r.wStrb[1]}}, {8{r.wStrb[0]}}};
		wrNew = (wrCur[31:0] & ~wrMask) | (r.wData & wrMask);
		wrUpd = r.wData[ardsp_pkg::UPDATE_BIT] & r.wStrb[1];
		if (!r.awready && !r.wready && !r.bvalid) begin
			n.awready = 1'b1;
			n.wready = 1'b1;
			n.bvalid = 1'b1;
			n.bresp = wrCur[32] ? ardsp_pkg::RESP_OKAY : ardsp_pkg::RESP_SLVERR;
			unique case (r.awIdx)
				ardsp_pkg::IDX_ATTEN: begin
					n.attenStage = wrNew[7:0];
					// a strobe landing on the apply edge survives
					if (wrUpd) begin
						n.attenPend = 1'b1;
					end
				end
				ardsp_pkg::IDX_A0_LOW, ardsp_pkg::IDX_A0_HIGH,
				ardsp_pkg::IDX_A1_LOW, ardsp_pkg::IDX_A1_HIGH: begin
					if (r.awIdx == ardsp_pkg::IDX_A0_LOW) begin
						n.coefZeroStage[6:0] = wrNew[6:0];
						n.notchOn = wrNew[ardsp_pkg::NOTCH_ON_BIT];
					end else if (r.awIdx == ardsp_pkg::IDX_A0_HIGH) begin
						n.coefZeroStage[13:7] = wrNew[6:0];
					end else if (r.awIdx == ardsp_pkg::IDX_A1_LOW) begin
						n.coefOneStage[6:0] = wrNew[6:0];
					end else begin
						n.coefOneStage[13:7] = wrNew[6:0];
					end
					if (wrUpd) begin
						n.notchPend = 1'b1;
					end
				end
				ardsp_pkg::IDX_GCTL1: begin
					n.gcOn = wrNew[ardsp_pkg::GC_ON_BIT];
					n.gainCeiling = wrNew[ardsp_pkg::CEIL_LSB +: 3];
					n.gainFloor = wrNew[2:0];
				end
				ardsp_pkg::IDX_GCTL2: begin
					n.riseDelay = wrNew[ardsp_pkg::HOLD_LSB +: 4];
					n.gcTarget = wrNew[3:0];
				end
				ardsp_pkg::IDX_GCTL3: begin
					n.gcKind = wrNew[ardsp_pkg::KIND_BIT];
					n.riseRate = wrNew[ardsp_pkg::RISE_LSB +: 4];
					n.fallRate = wrNew[3:0];
				end
				ardsp_pkg::IDX_CFG: begin
					n.rateSel = wrNew[2:0];
					n.staticGain = wrNew[ardsp_pkg::STATIC_LSB +: 6];
				end
				default: begin
				end
			endcase
		end

		// read side: answer one cycle after the address is taken
		rdRes = readReg(r, araddr[ardsp_pkg::ADDR_W-1:2]);
		if (rready && r.rvalid) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end
		if (arvalid && r.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = rdRes[31:0];
			n.rresp = rdRes[32] ? ardsp_pkg::RESP_OKAY : ardsp_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r <= '0;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
			r.inReady <= 1'b1;
			r.attenStage <= ardsp_pkg::RST_ATTEN;
			r.attenLive <= ardsp_pkg::RST_ATTEN;
			r.gainCeiling <= ardsp_pkg::RST_CEIL;
			r.gainFloor <= ardsp_pkg::RST_FLOOR;
			r.riseDelay <= ardsp_pkg::RST_HOLD;
			r.gcTarget <= ardsp_pkg::RST_TARGET;
			r.riseRate <= ardsp_pkg::RST_RISE;
			r.fallRate <= ardsp_pkg::RST_FALL;
			r.rateSel <= ardsp_pkg::RST_RATE;
			r.staticGain <= ardsp_pkg::RST_STATIC;
			r.pgaGain <= ardsp_pkg::RST_STATIC;
			r.gcState <= ardsp_pkg::GC_IDLE;
		end else begin
			r <= n;
		end
	end
endmodule : ardsp_top
`default_nettype wire

/* logic/ardsp_pkg.sv */
// constants, types and register map of the adc record path dsp block
`default_nettype none
package ardsp_pkg;
	localparam int SAMPLE_W = 24;
	localparam int COEF_W = 14;
	localparam int ADDR_W = 12;
	localparam int HALF_W = 7;
	// register indices, byte address is four times the index
	localparam logic [9:0] IDX_ATTEN = 10'h00f;
	localparam logic [9:0] IDX_A0_LOW = 10'h01b;
	localparam logic [9:0] IDX_A0_HIGH = 10'h01c;
	localparam logic [9:0] IDX_A1_LOW = 10'h01d;
	localparam logic [9:0] IDX_A1_HIGH = 10'h01e;
	localparam logic [9:0] IDX_GCTL1 = 10'h020;
	localparam logic [9:0] IDX_GCTL2 = 10'h021;
	localparam logic [9:0] IDX_GCTL3 = 10'h022;
	localparam logic [9:0] IDX_CFG = 10'h040;
	localparam logic [9:0] IDX_STATUS = 10'h041;
	localparam logic [9:0] IDX_COEF = 10'h042;
	// field positions
	localparam int UPDATE_BIT = 8;
	localparam int NOTCH_ON_BIT = 7;
	localparam int GC_ON_BIT = 8;
	localparam int CEIL_LSB = 3;
	localparam int HOLD_LSB = 4;
	localparam int KIND_BIT = 8;
	localparam int RISE_LSB = 4;
	localparam int STATIC_LSB = 4;
	localparam int ST_ATTEN_LSB = 8;
	localparam int ST_NOTCH_BIT = 16;
	localparam int ST_STATE_LSB = 17;
	localparam int COEF1_LSB = 14;
	// reset values
	localparam logic [7:0] RST_ATTEN = 8'hff;
	localparam logic [2:0] RST_CEIL = 3'h7;
	localparam logic [2:0] RST_FLOOR = 3'h0;
	localparam logic [3:0] RST_HOLD = 4'h0;
	localparam logic [3:0] RST_TARGET = 4'hb;
	localparam logic [3:0] RST_RISE = 4'h3;
	localparam logic [3:0] RST_FALL = 4'h2;
	localparam logic [2:0] RST_RATE = 3'h0;
	localparam logic [5:0] RST_STATIC = 6'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// arithmetic scales
	localparam int NOTCH_COEF_ZERO_SHIFT = 13;
	localparam int NOTCH_COEF_ONE_SHIFT = 12;
	localparam int FINE_SHIFT = 15;
	localparam logic [7:0] VOL_STEPS_PER_6DB = 8'h0c;
	localparam logic [7:0] VOL_TOP = 8'hff;
	localparam logic [3:0] LVL_TOP = 4'hf;
	localparam logic [3:0] LVL_FINE_STRIDE = 4'h3;
	localparam logic [3:0] RATE_SHIFT_MAX = 4'ha;
	localparam logic [2:0] RATE_SEL_MAX = 3'h5;
	localparam int LIMIT_SPEEDUP = 2;
	localparam logic [23:0] LEVEL_6DB = 24'h400000;
	localparam logic signed [23:0] SAMPLE_MAX = 24'sh7fffff;
	localparam logic signed [23:0] SAMPLE_MIN = -24'sh800000;
	// 10^(-k*0.5/20) in Q15
	localparam logic [15:0] VOL_FINE [0:11] = '{16'h8000, 16'h78d7, 16'h7215, 16'h6bb3,
		16'h65ad, 16'h5ffd, 16'h5a9e, 16'h558c, 16'h50c3, 16'h4c3f, 16'h47fb, 16'h43f4};
	// ramp and hold base times; gain moves 8 codes per 6 dB
	localparam longint HOLD_STEP_NS = 2670000;
	localparam longint RISE_PER6DB_NS = 3300000;
	localparam longint FALL_PER6DB_NS = 832000;
	localparam longint GAIN_CODES_PER_6DB = 8;
	localparam longint NS_PER_S = 1000000000;
	localparam int RATE_HZ [0:5] = '{48000, 32000, 24000, 16000, 12000, 8000};

	function automatic logic [23:0] ardsp_cnt(longint ns, int idx);
		longint c;
		c = ns * RATE_HZ[idx] / NS_PER_S;
		return (c < 1) ? 24'h000001 : c[23:0];
	endfunction : ardsp_cnt

	localparam logic [23:0] HOLD_BASE [0:5] = '{ardsp_cnt(HOLD_STEP_NS, 0),
		ardsp_cnt(HOLD_STEP_NS, 1), ardsp_cnt(HOLD_STEP_NS, 2), ardsp_cnt(HOLD_STEP_NS, 3),
		ardsp_cnt(HOLD_STEP_NS, 4), ardsp_cnt(HOLD_STEP_NS, 5)};
	localparam longint RISE_NS = RISE_PER6DB_NS / GAIN_CODES_PER_6DB;
	localparam longint FALL_NS = FALL_PER6DB_NS / GAIN_CODES_PER_6DB;
	localparam logic [23:0] RISE_BASE [0:5] = '{ardsp_cnt(RISE_NS, 0), ardsp_cnt(RISE_NS, 1),
		ardsp_cnt(RISE_NS, 2), ardsp_cnt(RISE_NS, 3), ardsp_cnt(RISE_NS, 4),
		ardsp_cnt(RISE_NS, 5)};
	localparam logic [23:0] FALL_BASE [0:5] = '{ardsp_cnt(FALL_NS, 0), ardsp_cnt(FALL_NS, 1),
		ardsp_cnt(FALL_NS, 2), ardsp_cnt(FALL_NS, 3), ardsp_cnt(FALL_NS, 4),
		ardsp_cnt(FALL_NS, 5)};

	typedef enum logic [3:0] {
		GC_IDLE = 4'h1,
		GC_FALL = 4'h2,
		GC_HOLD = 4'h4,
		GC_RISE = 4'h8
	} ardsp_gc_state_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [9:0] awIdx;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] attenStage;
		logic [7:0] attenLive;
		logic attenPend;
		logic [13:0] coefZeroStage;
		logic [13:0] coefOneStage;
		logic [13:0] coefZeroLive;
		logic [13:0] coefOneLive;
		logic notchOn;
		logic notchPend;
		logic gcOn;
		logic [2:0] gainCeiling;
		logic [2:0] gainFloor;
		logic [3:0] riseDelay;
		logic [3:0] gcTarget;
		logic gcKind;
		logic [3:0] riseRate;
		logic [3:0] fallRate;
		logic [2:0] rateSel;
		logic [5:0] staticGain;
		logic signed [23:0] x1;
		logic signed [23:0] x2;
		logic signed [23:0] ap1;
		logic signed [23:0] ap2;
		logic signed [23:0] buf0;
		logic signed [23:0] buf1;
		logic [1:0] cnt;
		logic outValid;
		logic inReady;
		ardsp_gc_state_t gcState;
		logic [23:0] gcCount;
		logic [5:0] pgaGain;
	} ardsp_state_t;
endpackage : ardsp_pkg
`default_nettype wire

/* tb/ardsp_asserts.sv */
// port-level checker for the record path block
`default_nettype none
module ardsp_asserts (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ardsp_pkg::ADDR_W-1:0] araddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic inValid,
	input wire logic inReady,
	input wire logic signed [23:0] outSample,
	input wire logic outValid,
	input wire logic outReady,
	input wire logic [5:0] pgaGain
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped early");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped early");
	wr_answer_a: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
		else $error("write answer late");
	aw_busy_a: assert property (awvalid && awready |=> !awready)
		else $error("second write address taken");
	rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	rd_refuse_a: assert property (arvalid && arready && araddr[11:2] == 10'h3ff |=>
		rresp == ardsp_pkg::RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	out_hold_a: assert property (outValid && !outReady |=> outValid && $stable(outSample))
		else $error("output sample lost");
	in_answer_a: assert property (inValid && inReady && !outValid |=> outValid)
		else $error("sample not passed on");
	empty_take_a: assert property (!outValid |-> inReady)
		else $error("empty buffer refuses");
	gain_sample_a: assert property (pgaGain != $past(pgaGain) |-> $past(inValid && inReady))
		else $error("gain moved between samples");
	cover property (bvalid && bresp == ardsp_pkg::RESP_SLVERR);
	cover property (inValid && !inReady);
	cover property (pgaGain == 6'h00);
	cover property (rvalid && !rready);
endmodule : ardsp_asserts
`default_nettype wire

/* tb/ardsp_adc_model.sv */
// decimator source and output sink at the sample stream ports
`default_nettype none
module ardsp_adc_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire logic stall,
	input wire logic signed [23:0] amp,
	input wire logic inReady,
	output var logic signed [23:0] inSample = 24'h0,
	output var logic inValid = 1'h0,
	output var logic outReady = 1'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] seq = 24'h1;
	always @(posedge mclk) begin
		outReady <= !stall;
		if (rst) begin
			inValid <= 1'h0;
		end else if (!inValid || inReady) begin
			inValid <= run;
			// idle lines flip so no stale value looks valid
			inSample <= run ? amp + seq : ~inSample;
			seq <= seq + 24'h1;
		end
	end
endmodule : ardsp_adc_model
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the record path block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
	logic awready, wready, bvalid, arready, rvalid, inValid, inReady, outValid, outReady;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic signed [23:0] inSample, outSample;
	logic signed [23:0] amp = 24'h0;
	logic [5:0] pgaGain;
	logic run = 1'h0, stall = 1'h0, watch = 1'h0, over = 1'h0;
	logic signed [23:0] inQ[$], outQ[$];
	int err_count = 0, comparisons = 0, cyc = 0;
	ardsp_top dut_u (.*);
	ardsp_adc_model adc_u (.*);
	always #4 mclk = !mclk;
	// mid-cycle view matches what the next edge takes
	always @(negedge mclk) begin
		if (inValid && inReady) inQ.push_back(inSample);
		if (outValid && outReady) outQ.push_back(outSample);
		if (watch && pgaGain > 6'h10) over = 1'h1;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			$display("MISMATCH %0t timeout", $time);
			close_out();
		end
	end
	task automatic close_out();
		$display("compares %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [9:0] i, input logic [31:0] v);
		@(posedge mclk);
		awaddr <= {i, 2'h0};
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) bready <= 1'h1;
		end while (bvalid !== 1'h1 || bready !== 1'h1);
		r = bresp;
	endtask : wr
	task automatic rd(input logic [9:0] i);
		@(posedge mclk);
		araddr <= {i, 2'h0};
		arvalid <= 1'h1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) rready <= 1'h1;
		end while (rvalid !== 1'h1 || rready !== 1'h1);
		d = rdata;
		r = rresp;
	endtask : rd
	task automatic rc(input logic [9:0] i, input logic [31:0] e, input string m);
		rd(i);
		chk(d, e, m);
		chk(r, ardsp_pkg::RESP_OKAY, m);
	endtask : rc
	// mode 0 pass, 1 mute, 2 unchecked, 3 half
	task automatic drain(input int mode);
		logic signed [23:0] e;
		run <= 1'h0;
		stall <= 1'h0;
		do @(posedge mclk); while (inValid === 1'h1 || outQ.size() < inQ.size());
		chk(outQ.size(), inQ.size(), "sample count");
		foreach (outQ[i]) begin
			e = mode == 1 ? 24'h0 : mode == 3 ? inQ[i] >>> 1 : inQ[i];
			if (mode != 2) chk(outQ[i], e, "sample value");
		end
		inQ.delete();
		outQ.delete();
	endtask : drain
	task automatic stream(input int n, input int mode);
		run <= 1'h1;
		do @(posedge mclk); while (inQ.size() < n);
		drain(mode);
	endtask : stream
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'h0;
		rc(ardsp_pkg::IDX_ATTEN, 32'h0ff, "atten reset");
		for (int i = 0; i < 4; i++) rc(ardsp_pkg::IDX_A0_LOW + 10'(i), 32'h0, "notch reset");
		rc(ardsp_pkg::IDX_GCTL1, 32'h038, "limits reset");
		rd(ardsp_pkg::IDX_STATUS);
		chk({d[15:8], d[5:0]}, 14'h3fd0, "status reset");
		// late ready on both answers, the slave must hold them
		rready <= 1'h0;
		rd(10'h3ff);
		chk(d, 32'h0, "read refuse data");
		chk(r, ardsp_pkg::RESP_SLVERR, "read refuse");
		bready <= 1'h0;
		wr(10'h3ff, 32'h1ff);
		chk(r, ardsp_pkg::RESP_SLVERR, "write refuse");
		$display("test reset and map done");
		stream(3, 0);
		stall <= 1'h1;
		run <= 1'h1;
		do @(posedge mclk); while (inReady !== 1'h0);
		chk(inQ.size(), 2, "buffer depth");
		drain(0);
		$display("test buffer done");
		wr(ardsp_pkg::IDX_ATTEN, 32'h000);
		stream(2, 0);
		rc(ardsp_pkg::IDX_ATTEN, 32'h000, "atten staged");
		wr(ardsp_pkg::IDX_ATTEN, 32'h100);
		stream(1, 2);
		stream(3, 1);
		wr(ardsp_pkg::IDX_ATTEN, 32'h1f3);
		stream(1, 2);
		stream(3, 3);
		rc(ardsp_pkg::IDX_ATTEN, 32'h0f3, "update kept");
		wr(ardsp_pkg::IDX_ATTEN, 32'h1ff);
		stream(1, 2);
		$display("test attenuation done");
		// a0 just above -0.5, a1 near 0.75
		wr(ardsp_pkg::IDX_A0_LOW, 32'h081);
		wr(ardsp_pkg::IDX_A0_HIGH, 32'h060);
		wr(ardsp_pkg::IDX_A1_LOW, 32'h005);
		rc(ardsp_pkg::IDX_COEF, 32'h0, "coef staged");
		wr(ardsp_pkg::IDX_A1_HIGH, 32'h118);
		stream(2, 2);
		rc(ardsp_pkg::IDX_COEF, {4'h0, 14'h0c05, 14'h3001}, "coef live");
		rc(ardsp_pkg::IDX_A1_HIGH, 32'h018, "notch update kept");
		rd(ardsp_pkg::IDX_STATUS);
		chk(d[16], 1'h1, "notch on");
		wr(ardsp_pkg::IDX_A0_LOW, 32'h001);
		$display("test notch done");
		wr(ardsp_pkg::IDX_CFG, 32'h200);
		stream(1, 2);
		chk(pgaGain, 6'h20, "static gain");
		wr(ardsp_pkg::IDX_CFG, 32'h100);
		wr(ardsp_pkg::IDX_GCTL3, 32'h000);
		wr(ardsp_pkg::IDX_GCTL2, 32'h000);
		wr(ardsp_pkg::IDX_GCTL1, 32'h11a);
		stream(600, 2);
		chk(pgaGain, 6'h1f, "ceiling");
		amp <= 24'sh700000;
		stream(100, 2);
		chk(pgaGain, 6'h10, "floor");
		$display("test level mode done");
		wr(ardsp_pkg::IDX_GCTL1, 32'h118);
		wr(ardsp_pkg::IDX_GCTL2, 32'h0f0);
		wr(ardsp_pkg::IDX_GCTL3, 32'h100);
		stream(40, 2);
		chk(pgaGain, 6'h00, "limiter fall");
		amp <= 24'sh0;
		watch <= 1'h1;
		stream(300, 2);
		watch <= 1'h0;
		chk(pgaGain, 6'h10, "limiter restore");
		chk(over, 1'h0, "limiter above static");
		$display("test limiter done");
		// leave the rise state so the next quiet spell starts a hold
		wr(ardsp_pkg::IDX_GCTL1, 32'h018);
		stream(1, 2);
		wr(ardsp_pkg::IDX_GCTL2, 32'h010);
		wr(ardsp_pkg::IDX_GCTL3, 32'h000);
		wr(ardsp_pkg::IDX_GCTL1, 32'h11a);
		stream(100, 2);
		chk(pgaGain, 6'h10, "hold wait");
		stream(250, 2);
		chk(pgaGain === 6'h10, 1'h0, "hold end");
		// slowest rate: one fall step per sample, floor well inside 21 samples
		wr(ardsp_pkg::IDX_CFG, 32'h105);
		amp <= 24'sh700000;
		stream(20, 2);
		chk(pgaGain, 6'h10, "rate scaled");
		$display("test hold done");
		close_out();
	end
endmodule : tb
bind ardsp_top ardsp_asserts chk_u (.*);
`default_nettype wire
